// ===== psm_ctrl.sv
/*
 * Power saving mode controller: run, slow, wait, slow-wait, halt, active
 * halt and timed wake-up halt, with interrupt mask forcing, wake-up
 * qualification and oscillator start-up delay.
 * Assumes the CPU core presents executed opcodes as one-cycle strobes and
 * that all inputs are synchronous to i_ref_clk.
 */
// Function
// - After reset run mode at full reference clock rate
// - Slow mode divides master clock 2,4,8,16
// - CPU and peripherals both use slow clock
// - Wait during slow mode keeps divided clock
// - Wait stops CPU, peripherals keep running
// - Wait entry forces interrupt mask to 10
// - Wait ends on interrupt or reset, vectoring
// - Push mask, set priority level, pop restores
// - Halt enters plain halt when both enables clear
// - Plain halt exits by reset or halt-capable interrupt
// - Halt exit restarts oscillator, waits 256 or 4096
// - Halt entry forces mask to 10, pending wakes
// - Plain halt stops oscillator and all processing
// - Watchdog option makes halt cause watchdog reset
// - Opcode 0x8E decodes as halt
// - Timebase enable alone selects active halt
// - Active halt exits by timebase, capable irq, reset
// - Active halt reset exit adds start-up delay
// - Active halt runs only oscillator and timebase counter
// - Active halt enabled suppresses watchdog halt reset
// - Auto wake-up enable alone selects timed halt
// - Timebase interrupt wakes only from active halt
`timescale 1ns/1ps

module psm_ctrl
   import psm_pkg::*;
(
   // Clock, enable and reset.
   input  wire logic        i_ref_clk,
   input  wire logic        i_clk_en,
   input  wire logic        i_resetn,
   // CPU core instruction strobes.
   input  wire logic        i_opcode_valid,
   input  wire logic [7:0]  i_opcode,
   input  wire logic        i_wait_for_interrupt_instr,
   input  wire logic        i_vector_taken,
   input  wire logic [1:0]  i_vector_level,
   input  wire logic        i_cc_pop,
   input  wire logic [1:0]  i_cc_pop_value,
   input  wire logic        i_cc_write,
   input  wire logic [1:0]  i_cc_write_value,
   // Wake-up sources.
   input  wire logic        i_irq_pending,
   input  wire logic        i_halt_exit_irq,
   input  wire logic        i_timebase_irq,
   input  wire logic        i_wakeup_timer_irq,
   input  wire logic        i_watchdog_enabled,
   // Avalon-MM slave.
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   // Clock and mode outputs.
   output logic             o_osc_enable,
   output logic             o_cpu_clk_en,
   output logic             o_periph_clk_en,
   output logic             o_timebase_clk_en,
   output logic             o_cpu_stall,
   output logic [1:0]       o_cc_mask,
   output logic             o_cc_push,
   output logic             o_watchdog_reset,
   output logic [2:0]       o_mode
);

   psm_mode_t   mode_reg;
   psm_mode_t   mode_next;
   logic [3:0]  mcc_reg;
   logic        awu_en_reg;
   logic [2:0]  opt_reg;
   logic [1:0]  cc_mask_reg;
   logic [12:0] startup_cnt_reg;
   logic [3:0]  div_cnt_reg;
   logic        ack_reg;
   logic        cpu_tick;
   logic        halt_exec;
   logic        halt_watchdog;
   logic [3:0]  div_mask;
   logic        run_like;

   assign halt_exec = i_opcode_valid && (i_opcode == PSM_HALT_OPCODE);
   // Active halt enabled suppresses the watchdog reset.
   assign halt_watchdog = halt_exec && opt_reg[PSM_WATCHDOG_HALT_BIT] && i_watchdog_enabled
      && !(mcc_reg[PSM_TIMEBASE_IRQ_EN_BIT] && !awu_en_reg);

   // Divider mask: slow select 0..3 gives divide by 2,4,8,16.
   always_comb
   begin
      case (mcc_reg[PSM_SLOW_DIV_LSB +: 2])
         2'd0:    div_mask = 4'h1;
         2'd1:    div_mask = 4'h3;
         2'd2:    div_mask = 4'h7;
         default: div_mask = 4'hF;
      endcase
   end

   // The slow tick feeds CPU and peripherals alike.
   assign cpu_tick = mcc_reg[PSM_SLOW_MODE_BIT] ? ((div_cnt_reg & div_mask) == 4'h0)
                                                : 1'b1;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         div_cnt_reg <= 4'h0;
      end
      else if (i_clk_en)
      begin
         div_cnt_reg <= div_cnt_reg + 4'h1;
      end
   end

   // Mode sequencing.
   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         PSM_RUN:
         begin
            if (i_wait_for_interrupt_instr)
            begin
               mode_next = PSM_WAIT;
            end
            else if (halt_exec && !halt_watchdog)
            begin
               if (mcc_reg[PSM_TIMEBASE_IRQ_EN_BIT] && !awu_en_reg)
               begin
                  mode_next = PSM_ACTIVE_HALT;
               end
               else if (awu_en_reg && !mcc_reg[PSM_TIMEBASE_IRQ_EN_BIT])
               begin
                  mode_next = PSM_TIMED_HALT;
               end
               else if (!awu_en_reg)
               begin
                  mode_next = PSM_HALT;
               end
            end
         end
         PSM_WAIT:
         begin
            if (i_irq_pending)
            begin
               mode_next = PSM_RUN;
            end
         end
         PSM_HALT:
         begin
            if (i_halt_exit_irq || i_irq_pending)
            begin
               mode_next = PSM_STARTUP;
            end
         end
         PSM_TIMED_HALT:
         begin
            if (i_halt_exit_irq || i_wakeup_timer_irq || i_irq_pending)
            begin
               mode_next = PSM_STARTUP;
            end
         end
         PSM_ACTIVE_HALT:
         begin
            // Oscillator is still running so no start-up delay on interrupt exit.
            if (i_halt_exit_irq || i_timebase_irq || i_irq_pending)
            begin
               mode_next = PSM_RUN;
            end
         end
         PSM_STARTUP:
         begin
            if (startup_cnt_reg == 13'h0001 && cpu_tick)
            begin
               mode_next = PSM_RUN;
            end
         end
         default:
         begin
            mode_next = PSM_RUN;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         mode_reg <= PSM_RUN;
      end
      else if (i_clk_en)
      begin
         mode_reg <= mode_next;
      end
   end

   // Start-up delay counter, loaded on exit from plain or timed halt into start-up.
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         startup_cnt_reg <= 13'h0000;
      end
      else if (i_clk_en)
      begin
         if (mode_next == PSM_STARTUP && mode_reg != PSM_STARTUP)
         begin
            startup_cnt_reg <= opt_reg[PSM_LONG_STARTUP_BIT] ? PSM_STARTUP_LONG
                                                             : PSM_STARTUP_SHORT;
         end
         else if (mode_reg == PSM_STARTUP && cpu_tick && startup_cnt_reg != 13'h0000)
         begin
            startup_cnt_reg <= startup_cnt_reg - 13'h0001;
         end
      end
   end

   // Reset exit from active halt: o_cpu_stall holds the CPU through the delay.
   logic        reset_delay_reg;
   logic [12:0] reset_cnt_reg;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         // The first reset cycle still sees active halt; later ones keep the flag.
         if (mode_reg == PSM_ACTIVE_HALT || reset_delay_reg)
         begin
            reset_delay_reg <= 1'b1;
         end
         else
         begin
            reset_delay_reg <= 1'b0;
         end
         reset_cnt_reg   <= opt_reg[PSM_LONG_STARTUP_BIT] ? PSM_STARTUP_LONG
                                                          : PSM_STARTUP_SHORT;
      end
      else if (i_clk_en && reset_delay_reg)
      begin
         reset_cnt_reg <= reset_cnt_reg - 13'h0001;
         if (reset_cnt_reg == 13'h0001)
         begin
            reset_delay_reg <= 1'b0;
         end
      end
   end

   // Condition code mask bits.
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         cc_mask_reg <= PSM_CC_MASK_RST;
         o_cc_push   <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_cc_push <= i_vector_taken;
         if (mode_reg == PSM_RUN && mode_next != PSM_RUN)
         begin
            cc_mask_reg <= PSM_CC_MASK_ENABLE_ALL;
         end
         else if (i_vector_taken)
         begin
            cc_mask_reg <= i_vector_level;
         end
         else if (i_cc_pop)
         begin
            cc_mask_reg <= i_cc_pop_value;
         end
         else if (i_cc_write)
         begin
            cc_mask_reg <= i_cc_write_value;
         end
      end
   end

   // Watchdog reset request on halt when the option allows it.
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         o_watchdog_reset <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_watchdog_reset <= halt_watchdog && mode_reg == PSM_RUN;
      end
   end

   assign run_like = (mode_reg == PSM_RUN || mode_reg == PSM_WAIT) && !reset_delay_reg;

   // Clock gating outputs.
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         o_osc_enable      <= 1'b1;
         o_cpu_clk_en      <= 1'b0;
         o_periph_clk_en   <= 1'b0;
         o_timebase_clk_en <= 1'b0;
         o_cpu_stall       <= 1'b1;
         o_mode            <= 3'h0;
      end
      else if (i_clk_en)
      begin
         o_osc_enable      <= !(mode_next == PSM_HALT || mode_next == PSM_TIMED_HALT);
         o_cpu_clk_en      <= cpu_tick && mode_reg == PSM_RUN && !reset_delay_reg;
         o_periph_clk_en   <= cpu_tick && run_like;
         o_timebase_clk_en <= cpu_tick && (run_like || mode_reg == PSM_ACTIVE_HALT);
         o_cpu_stall       <= mode_next != PSM_RUN || reset_delay_reg;
         o_mode            <= mode_next;
      end
   end

   // Register writes.
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         mcc_reg    <= PSM_MAIN_CLOCK_CTRL_RST;
         awu_en_reg <= PSM_AUTO_WAKEUP_RST;
         opt_reg    <= PSM_OPTION_RST;
      end
      else if (i_clk_en && i_avs_write && ack_reg)
      begin
         if (i_avs_address == PSM_MAIN_CLOCK_CTRL_OFS)
         begin
            mcc_reg <= i_avs_writedata[3:0];
         end
         else if (i_avs_address == PSM_WAKEUP_TIMER_CTRL_OFS)
         begin
            awu_en_reg <= i_avs_writedata[PSM_AUTO_WAKEUP_EN_BIT];
         end
         else if (i_avs_address == PSM_OPTION_OFS)
         begin
            opt_reg <= i_avs_writedata[2:0];
         end
      end
   end

   // One wait state per access; unmapped reads return zero.
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_resetn)
      begin
         ack_reg        <= 1'b0;
         o_avs_readdata <= 32'h0000_0000;
      end
      else if (i_clk_en)
      begin
         ack_reg <= (i_avs_read || i_avs_write) && !ack_reg;
         if (i_avs_read && !ack_reg)
         begin
            if (i_avs_address == PSM_MAIN_CLOCK_CTRL_OFS)
            begin
               o_avs_readdata <= {28'h000_0000, mcc_reg};
            end
            else if (i_avs_address == PSM_WAKEUP_TIMER_CTRL_OFS)
            begin
               o_avs_readdata <= {31'h0000_0000, awu_en_reg};
            end
            else if (i_avs_address == PSM_OPTION_OFS)
            begin
               o_avs_readdata <= {29'h0000_0000, opt_reg};
            end
            else if (i_avs_address == PSM_STATUS_OFS)
            begin
               o_avs_readdata <= {14'h0000, startup_cnt_reg, reset_delay_reg, cc_mask_reg,
                                  1'b0, mode_reg != PSM_RUN};
            end
            else
            begin
               o_avs_readdata <= 32'h0000_0000;
            end
         end
      end
   end

   assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;

   assign o_cc_mask = cc_mask_reg;

endmodule

// ===== psm_pkg.sv
/*
 * Package for the power saving mode controller: register offsets, field
 * positions, reset values, timing counts and mode enumeration.
 * Assumes a 40 MHz reference clock and a 32-bit Avalon-MM register bus.
 */
package psm_pkg;

   // Register byte offsets.
   localparam logic [3:0] PSM_MAIN_CLOCK_CTRL_OFS   = 4'h0;
   localparam logic [3:0] PSM_WAKEUP_TIMER_CTRL_OFS = 4'h4;
   localparam logic [3:0] PSM_OPTION_OFS            = 4'h8;
   localparam logic [3:0] PSM_STATUS_OFS            = 4'hC;

   // Main clock control register fields.
   localparam int PSM_SLOW_DIV_LSB         = 0;
   localparam int PSM_SLOW_MODE_BIT        = 2;
   localparam int PSM_TIMEBASE_IRQ_EN_BIT  = 3;
   // Wake-up timer control register fields.
   localparam int PSM_AUTO_WAKEUP_EN_BIT   = 0;
   // Option register fields.
   localparam int PSM_WATCHDOG_HALT_BIT    = 0;
   localparam int PSM_LONG_STARTUP_BIT     = 1;
   localparam int PSM_CLOCK_DOUBLE_BIT     = 2;

   // Reset values.
   localparam logic [3:0] PSM_MAIN_CLOCK_CTRL_RST = 4'h0;
   localparam logic       PSM_AUTO_WAKEUP_RST     = 1'b0;
   localparam logic [2:0] PSM_OPTION_RST          = 3'h0;
   localparam logic [1:0] PSM_CC_MASK_RST         = 2'h3;

   // Interrupt mask value forced on entry to wait and halt modes.
   localparam logic [1:0] PSM_CC_MASK_ENABLE_ALL  = 2'h2;

   // Halt opcode.
   localparam logic [7:0] PSM_HALT_OPCODE         = 8'h8E;

   // Oscillator stabilisation delays in CPU cycles.
   localparam logic [12:0] PSM_STARTUP_SHORT      = 13'h0100;
   localparam logic [12:0] PSM_STARTUP_LONG       = 13'h1000;

   // Power modes.
   typedef enum logic [2:0] {
      PSM_RUN,
      PSM_WAIT,
      PSM_HALT,
      PSM_ACTIVE_HALT,
      PSM_TIMED_HALT,
      PSM_STARTUP
   } psm_mode_t;

endpackage

// ===== psm_ctrl_sva.sv
/* Checker for the power saving mode controller, bound to psm_ctrl.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ps
module psm_ctrl_sva
   import psm_pkg::*;
(
   // Clock and reset.
   input wire logic       i_ref_clk,
   input wire logic       i_resetn,
   // Inputs watched.
   input wire logic       i_wait_for_interrupt_instr,
   input wire logic       i_vector_taken,
   input wire logic [1:0] i_vector_level,
   input wire logic       i_cc_pop,
   input wire logic       i_cc_write,
   input wire logic       i_irq_pending,
   input wire logic       i_halt_exit_irq,
   input wire logic       i_wakeup_timer_irq,
   input wire logic       i_avs_read,
   // Outputs watched.
   input wire logic       o_avs_waitrequest,
   input wire logic       o_osc_enable,
   input wire logic       o_cpu_clk_en,
   input wire logic       o_periph_clk_en,
   input wire logic       o_cpu_stall,
   input wire logic [1:0] o_cc_mask,
   input wire logic       o_cc_push,
   input wire logic       o_watchdog_reset,
   input wire logic [2:0] o_mode
);
   default clocking dcb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   reset_run_a:
      assert property ($past(!i_resetn) |-> o_mode == PSM_RUN && o_cc_mask == 2'h3)
      else $error("mode or mask wrong after reset");
   wait_mask_a:
      assert property (i_wait_for_interrupt_instr && o_mode == PSM_RUN && !i_irq_pending
         |-> ##[1:2] o_mode == PSM_WAIT && o_cc_mask == 2'h2)
      else $error("wait entry did not force mask");
   halt_mask_a:
      assert property (o_mode inside {PSM_HALT, PSM_ACTIVE_HALT, PSM_TIMED_HALT}
         && $stable(o_mode) |-> o_cc_mask == 2'h2)
      else $error("mask not forced in halt");
   halt_hold_a:
      assert property (o_mode == PSM_HALT && !i_irq_pending && !i_halt_exit_irq
         && !i_wakeup_timer_irq |=> o_mode == PSM_HALT)
      else $error("plain halt left without cause");
   active_wdg_a:
      assert property (o_mode == PSM_ACTIVE_HALT |-> !o_watchdog_reset)
      else $error("watchdog reset in active halt");
   active_clk_a:
      assert property (o_mode == PSM_ACTIVE_HALT && $past(o_mode) == PSM_ACTIVE_HALT
         |-> o_osc_enable && !o_periph_clk_en && !o_cpu_clk_en)
      else $error("wrong clocks in active halt");
   startup_stall_a:
      assert property (o_mode == PSM_STARTUP |-> o_cpu_stall && o_osc_enable)
      else $error("cpu not held during start-up");
   run_ticks_a:
      assert property (o_mode == PSM_RUN && $stable(o_mode) |-> o_cpu_clk_en == o_periph_clk_en)
      else $error("cpu and peripheral ticks differ");
   vector_mask_a:
      assert property (i_vector_taken && !i_cc_pop && !i_cc_write
         |=> o_cc_mask == $past(i_vector_level) && o_cc_push)
      else $error("vector did not push and set mask");
   bus_answer_a:
      assert property ($rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
      else $error("read answer timing wrong");

   wait_c: cover property (o_mode == PSM_WAIT);
   active_c: cover property (o_mode == PSM_ACTIVE_HALT);
   startup_c: cover property (o_mode == PSM_STARTUP);
endmodule

bind psm_ctrl psm_ctrl_sva u_sva (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
   .i_wait_for_interrupt_instr(i_wait_for_interrupt_instr), .i_vector_taken(i_vector_taken),
   .i_vector_level(i_vector_level), .i_cc_pop(i_cc_pop), .i_cc_write(i_cc_write),
   .i_irq_pending(i_irq_pending), .i_halt_exit_irq(i_halt_exit_irq),
   .i_wakeup_timer_irq(i_wakeup_timer_irq), .i_avs_read(i_avs_read),
   .o_avs_waitrequest(o_avs_waitrequest), .o_osc_enable(o_osc_enable),
   .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en), .o_cpu_stall(o_cpu_stall),
   .o_cc_mask(o_cc_mask), .o_cc_push(o_cc_push), .o_watchdog_reset(o_watchdog_reset),
   .o_mode(o_mode));

// ===== psm_cpu_model.sv
/* CPU core model: one-cycle strobes for executed opcodes, wait, vector
   entry, stack pop and mask write. Assumes one calling process. */
`timescale 1ns/1ps
module psm_cpu_model (
   // Clock.
   input  wire logic  i_ref_clk,
   // Strobes to the controller.
   output logic       o_op_valid,
   output logic [7:0] o_op,
   output logic       o_wfi,
   output logic       o_vec,
   output logic       o_pop,
   output logic       o_ccw,
   output logic [1:0] o_val
);
   initial
   begin
      {o_op_valid, o_wfi, o_vec, o_pop, o_ccw} = '0;
      o_op  = 8'h00;
      o_val = 2'h0;
   end

   // Kind 0 opcode, 1 wait, 2 vector, 3 pop, 4 mask write.
   task automatic strobe(input int kind, input logic [7:0] v);
      @(posedge i_ref_clk);
      o_op_valid <= kind == 0;
      o_wfi      <= kind == 1;
      o_vec      <= kind == 2;
      o_pop      <= kind == 3;
      o_ccw      <= kind == 4;
      o_op       <= v;
      o_val      <= v[1:0];
      @(posedge i_ref_clk);
      {o_op_valid, o_wfi, o_vec, o_pop, o_ccw} <= '0;
      // Released data lines must not keep the old value.
      o_op       <= ~v;
      o_val      <= ~v[1:0];
   endtask
endmodule

// ===== tb_power_saving_mode_control.sv
/* Testbench for the power saving mode controller: registers, slow rates,
   wait, halt, active and timed halt. Assumes the checker and CPU model. */
`timescale 1ns/1ps
module tb_power_saving_mode_control;
   import psm_pkg::*;
   logic        clk, rstn, rd, wr, wq, wen, osc, ce, pe, stall, wrst;
   logic        ov, wait_for_interrupt_instr, vec, pop, ccw, tbe;
   logic [3:0]  adr, src;
   logic [7:0]  op;
   logic [1:0]  val, mask;
   logic [2:0]  mode;
   logic [31:0] wd, rdat, q;
   int          n_mismatch, checks_done, seed, nc, np, n0, k, n, w, wc;

   psm_cpu_model u_cpu (.i_ref_clk(clk), .o_op_valid(ov), .o_op(op), .o_wfi(wait_for_interrupt_instr),
      .o_vec(vec), .o_pop(pop), .o_ccw(ccw), .o_val(val));
   psm_ctrl u_dut (.i_ref_clk(clk), .i_clk_en(1'b1), .i_resetn(rstn), .i_opcode_valid(ov),
      .i_opcode(op), .i_wait_for_interrupt_instr(wait_for_interrupt_instr), .i_vector_taken(vec),
      .i_vector_level(val), .i_cc_pop(pop), .i_cc_pop_value(val), .i_cc_write(ccw),
      .i_cc_write_value(val), .i_irq_pending(src[3]), .i_halt_exit_irq(src[2]),
      .i_timebase_irq(src[1]), .i_wakeup_timer_irq(src[0]), .i_watchdog_enabled(wen),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .o_osc_enable(osc), .o_cpu_clk_en(ce),
      .o_periph_clk_en(pe), .o_timebase_clk_en(tbe), .o_cpu_stall(stall), .o_cc_mask(mask),
      .o_cc_push(), .o_watchdog_reset(wrst), .o_mode(mode));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(negedge clk)
      if (wrst === 1'b1)
         w++;

   task automatic report_and_stop;
      $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
      checks_done++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED %0t: %s saw %h want %h", $time, m, s, e);
      end
   endtask

   task automatic hang;
      n_mismatch++;
      $display("CHECK FAILED %0t: wait ran out", $time);
      report_and_stop();
   endtask

   function automatic logic in_win(input int a, input int e);
      return a >= e - 4 && a <= e + 4;
   endfunction

   task automatic bus(input logic we, input int a, input logic [31:0] d);
      int i;
      @(posedge clk);
      adr <= a[3:0];
      wd  <= d;
      wr  <= we;
      rd  <= !we;
      i = 0;
      do
      begin
         @(negedge clk);
         i++;
      end
      while (wq !== 1'b0 && i < 40);
      if (wq !== 1'b0)
         hang();
      @(posedge clk);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic ticks;
      nc = 0;
      np = 0;
      repeat (32) @(posedge clk);
      repeat (320)
      begin
         @(negedge clk);
         nc += int'(ce === 1'b1);
         np += int'(pe === 1'b1);
      end
   endtask

   task automatic settle;
      n = 0;
      while (stall === 1'b1 && n < 6000)
      begin
         @(negedge clk);
         n++;
      end
      if (stall === 1'b1)
         hang();
   endtask

   task automatic wake(input logic [3:0] s);
      logic [2:0] m;
      m = mode;
      @(posedge clk);
      src <= s;
      n = 0;
      while (mode === m && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      if (mode === m)
         hang();
      @(posedge clk);
      src <= 4'h0;
      settle();
   endtask

   task automatic go_halt(input int ctl, input int awu, input int opt);
      bus(1, 0, ctl);
      bus(1, 4, awu);
      bus(1, 8, opt);
      wc = w;
      u_cpu.strobe(0, PSM_HALT_OPCODE);
      repeat (3) @(negedge clk);
   endtask

   initial
   begin
      seed = 32'h7e9a;
      {rstn, rd, wr, wen, src, adr, wd} = '0;
      {n_mismatch, checks_done, w} = '0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      chk(mode, PSM_RUN, "reset mode");
      chk(mask, 2'h3, "reset mask");
      for (k = 0; k < 12; k += 4)
      begin
         bus(0, k, 0);
         chk(q, 0, "reset value");
      end
      repeat (6)
      begin
         k = $random(seed);
         bus(1, 0, k);
         bus(1, 8, k);
         bus(1, 2, k);
         bus(1, 12, k);
         bus(0, 0, 0);
         chk(q, k & 15, "ctrl readback");
         bus(0, 8, 0);
         chk(q, k & 7, "option readback");
         bus(0, 2, 0);
         chk(q, 0, "unmapped read");
         bus(0, 12, 0);
         chk(q & 15, 12, "status");
      end
      bus(1, 8, 0);
      bus(1, 0, 0);
      ticks();
      n0 = nc;
      chk(n0 > 16, 1, "run ticks");
      chk(np, nc, "run periph rate");
      for (k = 0; k < 4; k++)
      begin
         bus(1, 0, 4 + k);
         ticks();
         chk(nc, n0 / (2 << k), "slow rate");
         chk(np, nc, "slow periph rate");
      end
      bus(1, 0, 5);
      u_cpu.strobe(1, 0);
      repeat (2) @(negedge clk);
      chk(mode, PSM_WAIT, "wait");
      chk(mask, 2'h2, "wait mask");
      chk(stall, 1, "wait stall");
      ticks();
      chk(np, n0 / 4, "slow wait rate");
      wake(4'h8);
      chk(mode, PSM_RUN, "wait exit");
      u_cpu.strobe(2, 1);
      @(negedge clk);
      chk(mask, 2'h1, "vector level");
      u_cpu.strobe(4, 0);
      @(negedge clk);
      chk(mask, 2'h0, "mask write");
      u_cpu.strobe(3, 3);
      @(negedge clk);
      chk(mask, 2'h3, "pop");
      for (k = 0; k < 2; k++)
      begin
         go_halt(0, 0, 2 * k);
         chk(mode, PSM_HALT, "halt");
         chk(osc, 0, "halt osc");
         chk(mask, 2'h2, "halt mask");
         @(posedge clk);
         src <= 4'h2;
         repeat (20) @(negedge clk);
         chk(mode, PSM_HALT, "timebase in halt");
         wake(4'h4);
         chk(in_win(n, k ? PSM_STARTUP_LONG : PSM_STARTUP_SHORT), 1, "startup");
      end
      @(posedge clk);
      wen <= 1'b1;
      nc = 0;
      for (k = 0; k < 2; k++)
      begin
         go_halt(0, 0, k);
         nc += w - wc;
         if (mode !== PSM_RUN)
            wake(4'h4);
         go_halt(8, 0, k);
         chk(mode, PSM_ACTIVE_HALT, "active halt");
         chk(osc, 1, "active osc");
         chk(mask, 2'h2, "active mask");
         chk(w - wc, 0, "active no reset");
         @(negedge clk);
         chk(tbe, 1, "active timebase tick");
         wake(4'h2);
         chk(n < 8, 1, "active irq exit");
      end
      chk(nc, 1, "watchdog option");
      @(posedge clk);
      wen <= 1'b0;
      go_halt(0, 1, 0);
      chk(mode, PSM_TIMED_HALT, "timed halt");
      chk(osc, 0, "timed osc");
      wake(4'h1);
      chk(in_win(n, PSM_STARTUP_SHORT), 1, "timed startup");
      go_halt(8, 1, 0);
      chk(mode, PSM_RUN, "both enables");
      bus(1, 4, 0);
      @(posedge clk);
      src <= 4'h8;
      go_halt(0, 0, 0);
      chk(mode === PSM_HALT, 0, "pending wakes");
      @(posedge clk);
      src <= 4'h0;
      settle();
      go_halt(8, 0, 0);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      settle();
      chk(in_win(n, PSM_STARTUP_SHORT), 1, "reset exit delay");
      report_and_stop();
   end
endmodule
